// *** swv_defs.svh ***
// Purpose: Shared constants of the scratchpad write/verify/copy logic.
// Assumes: Included by its bare name; definitions only.
// Notes:   Command codes, protection codes, address limits, reset values.
`ifndef SWV_DEFS_SVH
`define SWV_DEFS_SVH
`define SWV_CMD_WRITE_SP  8'h0F
`define SWV_CMD_READ_SP   8'hAA
`define SWV_CMD_COPY_SP   8'h55
`define SWV_CMD_READ_MEM  8'hF0
`define SWV_CMD_EXT_READ  8'hA5
`define SWV_PROT_WP       8'h55
`define SWV_PROT_EPROM    8'hAA
`define SWV_ADDR_LAST     16'h0A3F
`define SWV_REG_PAGE      16'h0A00
`define SWV_RO_PAGE       16'h0A20
`define SWV_CRC_POLY      16'hA001
`define SWV_OFF_LAST      5'h1F
`define SWV_PF_RST        1'b1
`define SWV_TA_RST        8'h00
`define SWV_E_RST         5'h00
`define SWV_ALT_BYTE      8'hAA
`define SWV_IDLE_BYTE     8'hFF
`define SWV_FIFO_DEPTH    8
`endif

// *** swv_pkg.sv ***
// Purpose: Types and the CRC16 bit step of the scratchpad command logic.
// Assumes: swv_defs.svh holds the numeric constants.
// Notes:   The CRC is kept in reflected form, bits enter LSB first.
`include "swv_defs.svh"
package swv_pkg;
	typedef logic [7:0] swv_byte_t;
	typedef logic [15:0] swv_addr_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_RS_HDR, ST_RS_DATA,
		ST_TX_CRC, ST_ONES, ST_CP_AUTH, ST_CP_PUSH, ST_CP_WAIT, ST_CP_ALT,
		ST_MR_ADDR
	} swv_state_e;

	function automatic logic [15:0] swv_crc_step(logic [15:0] crc,
		logic din);
		logic fb;
		fb = crc[0] ^ din;
		swv_crc_step = fb ? ((crc >> 1) ^ `SWV_CRC_POLY) : (crc >> 1);
	endfunction
endpackage

// *** swv_wr_if.sv ***
// Purpose: Valid/ready word carrier between the command logic and FIFO.
// Assumes: Source and sink share one clock.
// Notes:   A word moves in a cycle where valid and ready are both high.
interface swv_wr_if #(parameter int WIDTH = 24);
	logic [WIDTH-1:0] data;
	logic             valid;
	logic             ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// *** swv_fifo.sv ***
// Purpose: Small synchronous FIFO holding programming words.
// Assumes: DEPTH is a power of two.
// Notes:   Ready drops when full, so the copy engine stalls honestly.
`include "swv_defs.svh"
module swv_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = `SWV_FIFO_DEPTH
) (
	// Clock and reset
	input  logic             clk,
	input  logic             rst,
	// Filling side
	swv_wr_if.snk            in_port,
	// Draining side
	output logic             out_valid,
	input  logic             out_ready,
	output logic [WIDTH-1:0] out_data
);
	import swv_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;
	logic             full;
	logic             empty;

	assign empty = (wr_ptr_q == rd_ptr_q);
	assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
		(wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
	assign in_port.ready = !full;
	assign out_valid     = !empty;
	assign out_data      = mem_q[rd_ptr_q[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (in_port.valid && !full)
		begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_port.data;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
		end
		else if (in_port.valid && !full)
		begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_ptr_q <= '0;
		end
		else if (out_ready && !empty)
		begin
			rd_ptr_q <= rd_ptr_q + 1'b1;
		end
	end
endmodule

// *** swv_scratch_ctrl.sv ***
// Purpose: Memory-function command logic for scratchpad write, read, copy.
// Assumes: A bit-slot layer on the same clock delivers slot pulses.
// Notes:   The scratchpad lives here; EEPROM cells sit outside.
//
// Summary of operation
// RL1: Ending offset loads T[4:0], then counts bytes.
// RL2: Partial flag set on broken bytes or power loss.
// RL3: Status bit 6 always reads zero.
// RL4: Auth flag set by copy, cleared by writes.
// RL5: Write command takes address then data at T[4:0].
// RL6: Trailing incomplete byte dropped, partial flag set.
// RL7: Short address sets partial; full address clears flags.
// RL8: CRC16 over command, address and data bytes.
// RL9: At offset 31, read slots return inverted CRC.
// RL10: Write-protected target loads existing memory bytes.
// RL11: EPROM target loads data AND memory byte.
// RL12: Addresses above 0A3Fh lose top four bits.
// RL13: Read returns address, status, then scratchpad data.
// RL14: Read ends with inverted CRC of sent bytes.
// RL15: Read slots after read CRC return ones.
// RL16: Copy pattern must match address and status exactly.
// RL17: Copy needs match, valid address, clear flags, unlocked.
// RL18: Copy moves start through ending offset to memory.
// RL19: Master keeps bus idle during programming.
// RL20: After copy, read slots alternate zero and one.
// RL21: Memory read between write and copy sets bad-sequence.
// RL22: Master verifies by read when CRC missed.
// RL23: Protection byte 55h protects, AAh selects EPROM.
// RL24: Lock byte copy-protects write-protected blocks only.
// RL25: Reset pulse aborts command, returns to idle.
`include "swv_defs.svh"
module swv_scratch_ctrl (
	// Clock and reset
	input  logic                     clk,
	input  logic                     rst,
	// Bit-slot layer
	input  logic                     slot_reset,
	input  logic                     func_start,
	input  logic                     wr_slot,
	input  logic                     wr_bit,
	input  logic                     rd_slot,
	output logic                     rd_bit,
	// Protection bytes of the register page
	input  swv_pkg::swv_byte_t [9:0] block_prot,
	input  swv_pkg::swv_byte_t       block_lock,
	input  swv_pkg::swv_byte_t       page_lock,
	// EEPROM read port, data one cycle after address
	output swv_pkg::swv_addr_t       mem_rd_addr,
	input  swv_pkg::swv_byte_t       mem_rd_data,
	// EEPROM programming port
	output logic                     prog_valid,
	input  logic                     prog_ready,
	output swv_pkg::swv_addr_t       prog_addr,
	output swv_pkg::swv_byte_t       prog_data,
	input  logic                     prog_busy,
	// Address registers
	output swv_pkg::swv_byte_t       target_addr_low,
	output swv_pkg::swv_byte_t       target_addr_high,
	output swv_pkg::swv_byte_t       ending_offset_status
);
	import swv_pkg::*;

	swv_state_e state_q;
	swv_state_e st_d;
	swv_byte_t  sp_q [32];
	swv_byte_t  rx_q;
	logic [2:0] rx_cnt_q;
	swv_byte_t  tx_byte_q;
	swv_byte_t  tx_next;
	logic [2:0] tx_cnt_q;
	logic [1:0] idx_q;
	logic [1:0] idx_d;
	logic [4:0] off_q;
	logic [4:0] off_d;
	logic [15:0] crc_q;
	logic [15:0] crc_d;
	swv_byte_t  ta_lo_q;
	swv_byte_t  ta_hi_q;
	logic [4:0] e_q;
	logic       pf_q;
	logic       aa_q;
	logic       bs_q;
	logic       first_q;
	logic       settle_q;
	swv_addr_t  mem_rd_addr_q;

	logic       byte_done;
	logic       tx_done;
	logic       adv;
	swv_byte_t  rx_byte;
	swv_addr_t  ta;
	swv_byte_t  es;
	logic [4:0] wr_off;
	swv_byte_t  prot;
	logic       in_data;
	logic       wp;
	logic       eprom;
	logic       copy_prot;
	logic       cp_ok;
	swv_byte_t  auth_exp;
	swv_byte_t  sp_wdata;
	swv_byte_t  hi_masked;
	logic       push;
	logic       fifo_valid;
	logic [23:0] fifo_data;

	swv_wr_if #(.WIDTH(24)) push_if ();

	////////////////////////////////////////////////////////////////////////
	assign byte_done = wr_slot && (rx_cnt_q == 3'd7);
	assign tx_done   = rd_slot && (tx_cnt_q == 3'd7);
	assign rx_byte   = {wr_bit, rx_q[7:1]};
	assign ta        = {ta_hi_q, ta_lo_q};
	assign es        = {aa_q, 1'b0, pf_q, e_q}; // RL3
	assign wr_off    = first_q ? e_q : e_q + 5'd1;
	assign auth_exp  = (idx_q == 2'd0) ? ta_lo_q :
		(idx_q == 2'd1) ? ta_hi_q : es;

	// Protection is decoded from the target address held in the registers.
	assign in_data   = (ta < `SWV_REG_PAGE);
	assign prot      = in_data ? block_prot[ta[11:8]] : 8'h00;
	assign wp        = in_data ? (prot == `SWV_PROT_WP) : // RL23
		((ta >= `SWV_RO_PAGE) || (page_lock == `SWV_PROT_WP) ||
		(page_lock == `SWV_PROT_EPROM));
	assign eprom     = in_data && (prot == `SWV_PROT_EPROM); // RL23
	assign copy_prot = in_data ? ((prot == `SWV_PROT_WP) && // RL24
		((block_lock == `SWV_PROT_WP) ||
		(block_lock == `SWV_PROT_EPROM))) :
		((ta >= `SWV_RO_PAGE) || (page_lock == `SWV_PROT_WP) ||
		(page_lock == `SWV_PROT_EPROM));
	assign cp_ok     = (ta <= `SWV_ADDR_LAST) && !pf_q && !bs_q && // RL17
		!copy_prot;

	assign sp_wdata  = wp ? mem_rd_data : // RL10
		eprom ? (rx_byte & mem_rd_data) : rx_byte; // RL11
	assign hi_masked = ({rx_byte, ta_lo_q} > `SWV_ADDR_LAST) ? // RL12
		{4'h0, rx_byte[3:0]} : rx_byte;

	assign push      = (state_q == ST_CP_PUSH) && push_if.ready;
	assign push_if.valid = (state_q == ST_CP_PUSH);
	assign push_if.data  = {ta[15:5], off_q, sp_q[off_q]}; // RL18

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_d = state_q;
		unique case (state_q)
			ST_IDLE:
				if (func_start)
					st_d = ST_CMD;
			ST_CMD:
				if (byte_done)
				begin
					unique case (rx_byte)
						`SWV_CMD_WRITE_SP: st_d = ST_WS_ADDR; // RL5
						`SWV_CMD_READ_SP:  st_d = ST_RS_HDR; // RL13
						`SWV_CMD_COPY_SP:  st_d = ST_CP_AUTH; // RL16
						`SWV_CMD_READ_MEM: st_d = ST_MR_ADDR;
						`SWV_CMD_EXT_READ: st_d = ST_MR_ADDR;
						default:           st_d = ST_ONES;
					endcase
				end
			ST_WS_ADDR:
				if (byte_done && idx_q == 2'd1)
					st_d = ST_WS_DATA;
			ST_WS_DATA:
				if (byte_done && wr_off == `SWV_OFF_LAST)
					st_d = ST_TX_CRC; // RL9
			ST_RS_HDR:
				if (tx_done && idx_q == 2'd2)
					st_d = ST_RS_DATA;
			ST_RS_DATA:
				if (tx_done && off_q == `SWV_OFF_LAST)
					st_d = ST_TX_CRC; // RL14
			ST_TX_CRC:
				if (tx_done && idx_q == 2'd1)
					st_d = ST_ONES; // RL15
			ST_ONES:
				st_d = ST_ONES;
			ST_CP_AUTH:
				if (byte_done)
				begin
					if (rx_byte != auth_exp)
						st_d = ST_ONES; // RL16
					else if (idx_q == 2'd2)
						st_d = cp_ok ? ST_CP_PUSH : ST_ONES; // RL17
				end
			ST_CP_PUSH:
				if (push && off_q == e_q)
					st_d = ST_CP_WAIT;
			ST_CP_WAIT:
				// The bus is left alone while cells program.
				if (settle_q && !fifo_valid && !prog_busy)
					st_d = ST_CP_ALT; // RL19
			ST_CP_ALT:
				st_d = ST_CP_ALT;
			ST_MR_ADDR:
				// Another block serves the read; this one stays quiet.
				if (byte_done && idx_q == 2'd1)
					st_d = ST_ONES;
		endcase
		if (slot_reset)
			st_d = ST_IDLE; // RL25
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else
			state_q <= st_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Byte index and scratchpad offset used by the sequencers.
	always_comb
	begin
		adv = 1'b0;
		if (state_q inside {ST_WS_ADDR, ST_CP_AUTH, ST_MR_ADDR})
			adv = byte_done;
		else if (state_q inside {ST_RS_HDR, ST_TX_CRC})
			adv = tx_done;
		idx_d = (st_d != state_q) ? 2'd0 : (adv ? idx_q + 2'd1 : idx_q);
		off_d = off_q;
		if (st_d != state_q)
			off_d = ta_lo_q[4:0];
		else if ((state_q == ST_RS_DATA && tx_done) || push)
			off_d = off_q + 5'd1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			idx_q <= 2'd0;
			off_q <= `SWV_E_RST;
		end
		else
		begin
			idx_q <= idx_d;
			off_q <= off_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive shifter, LSB first; a reset pulse drops any partial byte.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rx_q     <= 8'h00;
			rx_cnt_q <= 3'd0;
		end
		else if (slot_reset || st_d != state_q)
		begin
			rx_q     <= 8'h00;
			rx_cnt_q <= 3'd0;
		end
		else if (wr_slot)
		begin
			rx_q     <= rx_byte;
			rx_cnt_q <= rx_cnt_q + 3'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		crc_d = crc_q;
		if (state_q == ST_IDLE)
			crc_d = 16'h0000; // RL8
		else if (wr_slot &&
			state_q inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA})
			crc_d = swv_crc_step(crc_q, wr_bit); // RL8
		else if (rd_slot && state_q inside {ST_RS_HDR, ST_RS_DATA})
			crc_d = swv_crc_step(crc_q, tx_byte_q[0]); // RL14
		if (state_q == ST_CMD && st_d == ST_RS_HDR)
			crc_d = 16'h0000;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			crc_q <= 16'h0000;
		else
			crc_q <= crc_d;
	end

	////////////////////////////////////////////////////////////////////////
	// The byte to present is chosen by the next state and index.
	always_comb
	begin
		unique case (st_d)
			ST_RS_HDR:
				tx_next = (idx_d == 2'd0) ? ta_lo_q : // RL13
					(idx_d == 2'd1) ? ta_hi_q : es;
			ST_RS_DATA:
				tx_next = sp_q[off_d]; // RL13
			ST_TX_CRC:
				tx_next = (idx_d == 2'd0) ? ~crc_d[7:0] : // RL9
					~crc_d[15:8]; // RL14
			ST_CP_ALT:
				tx_next = `SWV_ALT_BYTE; // RL20
			default:
				tx_next = `SWV_IDLE_BYTE; // RL15
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_byte_q <= `SWV_IDLE_BYTE;
			tx_cnt_q  <= 3'd0;
		end
		else if (st_d != state_q || tx_done)
		begin
			tx_byte_q <= tx_next;
			tx_cnt_q  <= 3'd0;
		end
		else if (rd_slot)
		begin
			tx_byte_q <= {1'b1, tx_byte_q[7:1]};
			tx_cnt_q  <= tx_cnt_q + 3'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scratchpad storage takes whole bytes only.
	always_ff @(posedge clk)
	begin
		if (state_q == ST_WS_DATA && byte_done)
			sp_q[wr_off] <= sp_wdata; // RL6
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			mem_rd_addr_q <= 16'h0000;
		else
			mem_rd_addr_q <= {ta[15:5], wr_off};
	end

	////////////////////////////////////////////////////////////////////////
	// Address registers and status flags. The partial flag starts set since
	// the scratchpad holds nothing valid after power comes up.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ta_lo_q <= `SWV_TA_RST;
			ta_hi_q <= `SWV_TA_RST;
			e_q     <= `SWV_E_RST;
			pf_q    <= `SWV_PF_RST; // RL2
			aa_q    <= 1'b0;
			bs_q    <= 1'b0;
			first_q <= 1'b1;
		end
		else if (slot_reset)
		begin
			if (state_q == ST_WS_ADDR)
				pf_q <= 1'b1; // RL7
			else if (state_q == ST_WS_DATA && rx_cnt_q != 3'd0)
				pf_q <= 1'b1; // RL6
		end
		else
		begin
			if (state_q == ST_CMD && byte_done &&
				(rx_byte == `SWV_CMD_READ_MEM ||
				rx_byte == `SWV_CMD_EXT_READ))
				bs_q <= 1'b1; // RL21
			if (state_q inside {ST_WS_ADDR, ST_MR_ADDR} && byte_done)
			begin
				if (idx_q == 2'd0)
					ta_lo_q <= rx_byte; // RL5
				else
					ta_hi_q <= hi_masked; // RL12
			end
			if (state_q == ST_WS_ADDR && byte_done && idx_q == 2'd1)
			begin
				pf_q    <= 1'b0; // RL7
				bs_q    <= 1'b0; // RL7
				e_q     <= ta_lo_q[4:0]; // RL1
				first_q <= 1'b1;
			end
			if (state_q == ST_WS_DATA && byte_done)
			begin
				e_q     <= wr_off; // RL1
				first_q <= 1'b0;
				aa_q    <= 1'b0; // RL4
			end
			if (state_q == ST_CP_AUTH && st_d == ST_CP_PUSH)
				aa_q <= 1'b1; // RL4
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			settle_q <= 1'b0;
		else
			settle_q <= (state_q == ST_CP_WAIT) && !fifo_valid;
	end

	////////////////////////////////////////////////////////////////////////
	// Programming words queue here so a slow cell array stalls the copy.
	swv_fifo #(
		.WIDTH (24),
		.DEPTH (`SWV_FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_port   (push_if),
		.out_valid (fifo_valid),
		.out_ready (prog_ready),
		.out_data  (fifo_data)
	);

	assign prog_valid           = fifo_valid;
	assign prog_addr            = fifo_data[23:8];
	assign prog_data            = fifo_data[7:0];
	assign rd_bit               = tx_byte_q[0];
	assign mem_rd_addr          = mem_rd_addr_q;
	assign target_addr_low      = ta_lo_q;
	assign target_addr_high     = ta_hi_q;
	assign ending_offset_status = es;
endmodule

// *** swv_master_model.sv ***
// Purpose: Behavioural bus master issuing reset pulses and bit slots.
// Assumes: Strobes change on the falling edge, slots two cycles apart.
// Notes:   A released write line shows the inverse of its last bit.
module swv_master_model (
	// Clock and answer
	input  logic clk,
	input  logic rd_bit,
	// Slot strobes
	output logic slot_reset,
	output logic func_start,
	output logic wr_slot,
	output logic wr_bit,
	output logic rd_slot
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		slot_reset = 1'b0;
		func_start = 1'b0;
		wr_slot = 1'b0;
		wr_bit = 1'b0;
		rd_slot = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic reset_pulse();
		@(negedge clk);
		slot_reset = 1'b1;
		@(negedge clk);
		slot_reset = 1'b0;
	endtask
	task automatic start();
		@(negedge clk);
		func_start = 1'b1;
		@(negedge clk);
		func_start = 1'b0;
	endtask
	// Strobes idle low between slots, so no slot disturbs programming.
	task automatic slot(input logic w, input logic b, output logic r);
		@(negedge clk);
		wr_slot = w;
		rd_slot = !w;
		wr_bit = b;
		r = rd_bit;
		@(negedge clk);
		wr_slot = 1'b0;
		rd_slot = 1'b0;
		wr_bit = !b;
	endtask
	task automatic wbits(input logic [7:0] v, input int n);
		logic r;
		for (int i = 0; i < n; i++)
			slot(1'b1, v[i], r);
	endtask
	task automatic rbyte(output logic [7:0] v);
		for (int i = 0; i < 8; i++)
			slot(1'b0, 1'b1, v[i]);
	endtask
endmodule

// *** swv_scratch_ctrl_sva.sv ***
// Purpose: Port-level checks of the scratchpad command logic.
// Assumes: Bound to swv_scratch_ctrl; one clock domain.
// Notes:   Copy checks assume no new write while old words still drain.
module swv_scratch_ctrl_sva (
	// Clock and reset
	input logic               clk,
	input logic               rst,
	// Ports watched
	input swv_pkg::swv_addr_t mem_rd_addr,
	input logic               prog_valid,
	input logic               prog_ready,
	input swv_pkg::swv_addr_t prog_addr,
	input swv_pkg::swv_byte_t prog_data,
	input swv_pkg::swv_byte_t target_addr_low,
	input swv_pkg::swv_byte_t target_addr_high,
	input swv_pkg::swv_byte_t ending_offset_status
);
	import swv_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////
	property p_bit6;
		ending_offset_status[6] == 1'b0;
	endproperty
	a_bit6: assert property (p_bit6) else $error("status bit 6 set");
	property p_e_step;
		$changed(ending_offset_status[4:0]) |->
			ending_offset_status[4:0] == $past(ending_offset_status[4:0]) + 5'h01
			|| ending_offset_status[4:0] == target_addr_low[4:0];
	endproperty
	a_e_step: assert property (p_e_step) else $error("bad offset step");
	property p_aa_rise;
		$rose(ending_offset_status[7]) |-> ending_offset_status[5] == 1'b0;
	endproperty
	a_aa_rise: assert property (p_aa_rise) else $error("auth with partial");
	property p_ta_nib;
		target_addr_high[7:4] == 4'h0;
	endproperty
	a_ta_nib: assert property (p_ta_nib) else $error("address not masked");
	property p_addr_nib;
		mem_rd_addr[15:12] == 4'h0 && (!prog_valid || prog_addr[15:12] == 4'h0);
	endproperty
	a_addr_nib: assert property (p_addr_nib) else $error("wide address");
	property p_hold;
		prog_valid && !prog_ready |=>
			prog_valid && $stable(prog_addr) && $stable(prog_data);
	endproperty
	a_hold: assert property (p_hold) else $error("word dropped");
	property p_ascend;
		prog_valid && prog_ready |=>
			!prog_valid || prog_addr == $past(prog_addr) + 16'h0001;
	endproperty
	a_ascend: assert property (p_ascend) else $error("word out of order");
	property p_in_range;
		prog_valid |-> prog_addr[15:5] == {target_addr_high, target_addr_low[7:5]}
			&& prog_addr[4:0] >= target_addr_low[4:0]
			&& prog_addr[4:0] <= ending_offset_status[4:0];
	endproperty
	a_in_range: assert property (p_in_range) else $error("word outside");
	property p_prog_aa;
		prog_valid |-> ending_offset_status[7];
	endproperty
	a_prog_aa: assert property (p_prog_aa) else $error("copy without auth");
	cover property (prog_valid && prog_ready);
endmodule

// *** swv_scratch_ctrl_bench.sv ***
// Purpose: Self-checking bench of the scratchpad write, read and copy.
// Assumes: Memory byte at address a reads a[7:0] ^ 5Ah; block 1 is
//          write protected and block 2 in EPROM mode.
// Notes:   Inputs change on the falling edge only.
`include "swv_defs.svh"
module swv_scratch_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import swv_pkg::*;
	typedef struct {logic [15:0] a; int n; int mode; swv_byte_t hi, st;} swv_row_s;
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                slot_reset, func_start, wr_slot, wr_bit, rd_slot, rd_bit;
	swv_byte_t [9:0]     block_prot;
	swv_byte_t           block_lock, page_lock, mem_rd_data, prog_data;
	swv_byte_t           target_addr_low, target_addr_high, ending_offset_status;
	swv_addr_t           mem_rd_addr, prog_addr;
	logic                prog_valid, prog_ready, prog_busy, hold_ready;
	logic [23:0]         words[$];
	logic [15:0]         crc;
	int                  busy_cnt = 0;
	int                  n_errors = 0;
	int                  check_count = 0;
	swv_row_s rows[4] = '{'{16'h0010, 4, 0, 8'h00, 8'h13},
		'{16'h0118, 8, 1, 8'h01, 8'h1F}, '{16'h0205, 3, 2, 8'h02, 8'h07},
		'{16'hF3E0, 32, 0, 8'h03, 8'h1F}};
	always #5 clk = ~clk;
	swv_scratch_ctrl swv_scratch_ctrl_inst (.clk, .rst, .slot_reset,
		.func_start, .wr_slot, .wr_bit, .rd_slot, .rd_bit, .block_prot,
		.block_lock, .page_lock, .mem_rd_addr, .mem_rd_data, .prog_valid,
		.prog_ready, .prog_addr, .prog_data, .prog_busy, .target_addr_low,
		.target_addr_high, .ending_offset_status);
	swv_master_model swv_master_model_inst (.clk, .rd_bit, .slot_reset,
		.func_start, .wr_slot, .wr_bit, .rd_slot);
	////////////////////////////////////////////////////////////////////////
	// Ready toggles so that the FIFO always faces a sink that stalls.
	always @(negedge clk)
	begin
		// Record the word that the coming rising edge will take.
		if (prog_valid === 1'b1 && !hold_ready && !prog_ready)
		begin
			words.push_back({prog_addr, prog_data});
			busy_cnt = 6;
		end
		else if (busy_cnt != 0)
			busy_cnt = busy_cnt - 1;
		prog_busy <= busy_cnt != 0;
		prog_ready <= !hold_ready && !prog_ready;
		mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5A;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] v);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ v[i]) ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		return c;
	endfunction
	function automatic swv_byte_t sp_byte(swv_row_s r, int i);
		swv_byte_t d, m;
		d = 8'h30 + 8'(i);
		m = (r.a[7:0] + 8'(i)) ^ 8'h5A;
		case (r.mode)
			1: return m;
			2: return d & m;
			default: return d;
		endcase
	endfunction
	task automatic check(input string what, input logic [23:0] seen, exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic send(input swv_byte_t v);
		swv_master_model_inst.wbits(v, 8);
		crc = crc_byte(crc, v);
	endtask
	task automatic recv(output swv_byte_t v);
		swv_master_model_inst.rbyte(v);
		crc = crc_byte(crc, v);
	endtask
	task automatic cmd(input swv_byte_t c);
		swv_master_model_inst.reset_pulse();
		swv_master_model_inst.start();
		crc = 16'h0000;
		send(c);
	endtask
	task automatic wr_sp(input logic [15:0] a, input int n);
		cmd(`SWV_CMD_WRITE_SP);
		send(a[7:0]);
		send(a[15:8]);
		for (int i = 0; i < n; i++)
			send(8'h30 + 8'(i));
	endtask
	task automatic copy(input swv_byte_t lo, hi, st);
		cmd(`SWV_CMD_COPY_SP);
		send(lo);
		send(hi);
		send(st);
	endtask
	task automatic rd_crc(input string what);
		logic [15:0] c;
		swv_byte_t   b0, b1;
		c = ~crc;
		swv_master_model_inst.rbyte(b0);
		swv_master_model_inst.rbyte(b1);
		check(what, {b1, b0}, c);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		swv_byte_t b;
		block_prot = '0;
		block_prot[1] = 8'h55;
		block_prot[2] = 8'hAA;
		block_lock = 8'h00;
		page_lock = 8'h00;
		hold_ready = 1'b0;
		prog_ready = 1'b0;
		prog_busy = 1'b0;
		mem_rd_data = 8'h00;
		repeat (5) @(negedge clk);
		check("rst_es", ending_offset_status, 8'h20);
		check("rst_out", {prog_valid, rd_bit, target_addr_high,
			target_addr_low}, {1'b0, 1'b1, 16'h0000});
		rst = 1'b0;
		for (int r = 0; r < 4; r++)
		begin
			wr_sp(rows[r].a, rows[r].n);
			if (rows[r].st[4:0] == 5'h1F)
				rd_crc("wr_crc");
			cmd(`SWV_CMD_READ_SP);
			crc = 16'h0000;
			recv(b);
			check("rd_lo", b, rows[r].a[7:0]);
			recv(b);
			check("rd_hi", b, rows[r].hi);
			recv(b);
			check("rd_es", b, rows[r].st);
			for (int i = 0; i < rows[r].n; i++)
			begin
				recv(b);
				check("rd_data", b, sp_byte(rows[r], i));
			end
			if (rows[r].st[4:0] == 5'h1F)
			begin
				rd_crc("rd_crc");
				swv_master_model_inst.rbyte(b);
				check("rd_ones", b, 8'hFF);
			end
		end
		hold_ready = 1'b1;
		copy(8'hE0, 8'h03, 8'h1F);
		repeat (100) @(negedge clk);
		hold_ready = 1'b0;
		for (int k = 0; k < 3000 && (words.size() < 32 || prog_busy); k++)
			@(negedge clk);
		repeat (4) @(negedge clk);
		check("drained", {words.size() == 32, prog_busy}, 2'b10);
		for (int i = 0; i < 32; i++)
			check("word", words[i], {16'h03E0 + 16'(i), 8'h30 + 8'(i)});
		check("es_copy", ending_offset_status, 8'h9F);
		swv_master_model_inst.rbyte(b);
		check("alt", b, 8'hAA);
		wr_sp(16'h0040, 2);
		swv_master_model_inst.wbits(8'h00, 5);
		swv_master_model_inst.reset_pulse();
		check("partial", ending_offset_status, 8'h21);
		wr_sp(16'h0040, 0);
		check("addr_ok", ending_offset_status[5], 1'b0);
		cmd(`SWV_CMD_WRITE_SP);
		send(8'h40);
		swv_master_model_inst.reset_pulse();
		check("short", ending_offset_status[5], 1'b1);
		wr_sp(16'h0040, 1);
		cmd(`SWV_CMD_READ_MEM);
		send(8'h40);
		send(8'h00);
		copy(8'h40, 8'h00, 8'h00);
		swv_master_model_inst.rbyte(b);
		check("bad_seq", {words.size() == 32, b}, {1'b1, 8'hFF});
		wr_sp(16'h0040, 1);
		cmd(`SWV_CMD_EXT_READ);
		send(8'h40);
		send(8'h00);
		copy(8'h40, 8'h00, 8'h00);
		swv_master_model_inst.rbyte(b);
		check("bad_ext", {words.size() == 32, b}, {1'b1, 8'hFF});
		wr_sp(16'h0040, 1);
		copy(8'h40, 8'h00, 8'h01);
		swv_master_model_inst.rbyte(b);
		check("bad_auth", {words.size() == 32, b}, {1'b1, 8'hFF});
		block_lock = 8'h55;
		wr_sp(16'h0100, 1);
		copy(8'h00, 8'h01, 8'h00);
		swv_master_model_inst.rbyte(b);
		check("locked", {words.size() == 32, b}, {1'b1, 8'hFF});
		// A reset in mid-run must bring back the power-up status.
		wr_sp(16'h0041, 1);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		check("rst_mid", ending_offset_status, 8'h20);
		rst = 1'b0;
		copy(8'h00, 8'h00, 8'h20);
		swv_master_model_inst.rbyte(b);
		check("rst_copy", {words.size() == 32, b}, {1'b1, 8'hFF});
		stop_test();
	end
	initial
	begin
		#400000;
		n_errors++;
		stop_test();
	end
endmodule
bind swv_scratch_ctrl swv_scratch_ctrl_sva swv_scratch_ctrl_sva_inst (.clk,
	.rst, .mem_rd_addr, .prog_valid, .prog_ready, .prog_addr, .prog_data,
	.target_addr_low, .target_addr_high, .ending_offset_status);
